// File: ftc_defines.vh
// Function
// - sample time, interval, delta at once
// - completion event carries command descriptor address
// - event slot zero, parameter only bit 12
// - word 00h holds system time high
// - word 04h holds system time low
// - word 08h written as zero
// - interval counter in bits 29:16
// - delta in bits 12:0 at 0Ch
// - only physical function shows virtualization capability
// - real runtime and doorbell sets per function
// - filter function accesses to owned sets
// - separate runtime and doorbell base offsets
`ifndef FTC_DEFINES_VH
`define FTC_DEFINES_VH
// command fields
`define FTC_CAP_BIT 12
`define FTC_SUB_GET_TS 3'h1
// context layout
`define FTC_CTX_OFF_HI 64'h0000000000000000
`define FTC_CTX_OFF_LO 64'h0000000000000004
`define FTC_CTX_OFF_RSV 64'h0000000000000008
`define FTC_CTX_OFF_BI 64'h000000000000000C
`define FTC_BI_MSB 29
`define FTC_BI_LSB 16
`define FTC_DT_MSB 12
`define FTC_BEATS 2'h3
// event fields
`define FTC_PARAM_TS 24'h001000
`define FTC_PARAM_NONE 24'h000000
`define FTC_SLOT_ZERO 8'h00
// register byte offsets
`define FTC_REG_CTRL 12'h000
`define FTC_REG_STAT 12'h004
`define FTC_REG_MASK 12'h008
`define FTC_REG_RTSOFF 12'h00C
`define FTC_REG_DBOFF 12'h010
`define FTC_REG_DBMAP 12'h014
`define FTC_REG_IRMAP 12'h018
`define FTC_REG_COUNT 12'h01C
// status bits
`define FTC_ST_DONE 0
`define FTC_ST_ERR 1
`define FTC_ST_DENY 2
`define FTC_ST_W 3
// reset values
`define FTC_RTSOFF_RST 32'h00002000
`define FTC_DBOFF_RST 32'h00003000
`define FTC_OFF_ALIGN 32'hFFFFF000
`define FTC_ZERO32 32'h00000000
`endif

// File: ftc_set_filter.v
`timescale 1ns/1ps
// ownership lookup for runtime and doorbell register sets
module ftc_set_filter #(
  parameter NSETS = 8,
  parameter FW = 3,
  parameter SW = 3
) (
  // access
  input wire [FW-1:0] accFn,
  input wire accIsDb,
  input wire [SW-1:0] accSet,
  // ownership tables, one field per set
  input wire [NSETS*FW-1:0] dbOwner,
  input wire [NSETS*FW-1:0] irOwner,
  // result
  output wire grant
);
  function [FW-1:0] ownerOf;
    input [NSETS*FW-1:0] tbl;
    input [SW-1:0] idx;
    begin
      ownerOf = tbl[idx*FW +: FW];
    end
  endfunction
  wire [FW-1:0] dbOwn;
  wire [FW-1:0] irOwn;
  assign dbOwn = ownerOf(dbOwner, accSet);
  // interrupter set 0 always belongs to the physical function
  assign irOwn = (accSet == {SW{1'b0}}) ? {FW{1'b0}} : ownerOf(irOwner, accSet);
  // each function reaches only its own sets, exclusively
  assign grant = accIsDb ? (dbOwn == accFn) : (irOwn == accFn);
endmodule // ftc_set_filter

// File: ftc_time_corr.v
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ftc_defines.vh"
module ftc_time_corr #(
  parameter NSETS = 8,
  parameter FW = 3,
  parameter SW = 3,
  parameter [7:0] CODE_OK = 8'h01,
  parameter [7:0] CODE_BAD = 8'h05
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // command in
  input wire cmdValid,
  output reg cmdReady,
  input wire [63:0] cmdAddr,
  input wire [63:0] cmdCtxPtr,
  input wire [15:0] cmdCapSel,
  input wire [2:0] cmdSubtype,
  input wire [7:0] cmdSlot,
  input wire [4:0] cmdEp,
  input wire cmdIsSet,
  // time sources
  input wire [63:0] sysTime,
  input wire [13:0] busInterval,
  input wire [12:0] deltaTime,
  // memory write
  output reg memValid,
  input wire memReady,
  output reg [63:0] memAddr,
  output reg [31:0] memData,
  // completion event
  output reg evtValid,
  input wire evtReady,
  output reg [63:0] evtCmdPtr,
  output reg [7:0] evtSlot,
  output reg [23:0] evtParam,
  output reg [7:0] evtCode,
  // function access check
  input wire accValid,
  input wire [FW-1:0] accFn,
  input wire accIsDb,
  input wire [SW-1:0] accSet,
  output reg accGrant,
  output reg accDone,
  output reg virtCapVisible,
  // interrupt
  output reg irq
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WR = 4'b0010;
  localparam [3:0] ST_EVT = 4'b0100;
  localparam [3:0] ST_PRE = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] beat_q;
  reg [63:0] ctx_q;
  reg [63:0] cmdPtr_q;
  reg good_q;
  reg [63:0] tsTime_q;
  reg [13:0] tsBi_q;
  reg [12:0] tsDt_q;
  reg enable_q;
  reg [`FTC_ST_W-1:0] stat_q;
  reg [`FTC_ST_W-1:0] mask_q;
  reg [31:0] rtsOff_q;
  reg [31:0] dbOff_q;
  reg [NSETS*FW-1:0] dbMap_q;
  reg [NSETS*FW-1:0] irMap_q;
  reg [31:0] count_q;

  wire setupPh;
  wire accessPh;
  wire wrEn;
  wire take;
  wire cmdOk;
  wire grantW;
  wire evDone;
  wire evErr;
  wire evDeny;
  wire [`FTC_ST_W-1:0] evVec;
  wire [`FTC_ST_W-1:0] w1c;
  wire [`FTC_ST_W-1:0] stat_d;

  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrEn = accessPh & pwrite & pready;

  function mapped;
    input [11:0] a;
    begin
      case (a)
        `FTC_REG_CTRL, `FTC_REG_STAT, `FTC_REG_MASK, `FTC_REG_RTSOFF,
        `FTC_REG_DBOFF, `FTC_REG_DBMAP, `FTC_REG_IRMAP, `FTC_REG_COUNT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // context word by beat; word 08h stays zero
  function [31:0] ctxWord;
    input [1:0] b;
    input [63:0] t;
    input [13:0] bi;
    input [12:0] dt;
    begin
      case (b)
        2'h0: ctxWord = t[63:32];
        2'h1: ctxWord = t[31:0];
        2'h2: ctxWord = `FTC_ZERO32;
        default: begin
          ctxWord = `FTC_ZERO32;
          ctxWord[`FTC_BI_MSB:`FTC_BI_LSB] = bi;
          ctxWord[`FTC_DT_MSB:0] = dt;
        end
      endcase
    end
  endfunction

  function [63:0] ctxOff;
    input [1:0] b;
    begin
      case (b)
        2'h0: ctxOff = `FTC_CTX_OFF_HI;
        2'h1: ctxOff = `FTC_CTX_OFF_LO;
        2'h2: ctxOff = `FTC_CTX_OFF_RSV;
        default: ctxOff = `FTC_CTX_OFF_BI;
      endcase
    end
  endfunction

  // malformed queries complete with an error code and write nothing
  assign cmdOk = cmdCapSel[`FTC_CAP_BIT] & ~cmdIsSet & (cmdSubtype == `FTC_SUB_GET_TS)
    & (cmdSlot == 8'h00) & (cmdEp == 5'h00);
  assign take = cmdValid & cmdReady;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = cmdOk ? ST_PRE : ST_EVT;
        end
      end
      ST_PRE: state_d = ST_WR;
      ST_WR: begin
        // event follows only after the last context write is accepted
        if (memValid & memReady & (beat_q == `FTC_BEATS)) begin
          state_d = ST_EVT;
        end
      end
      ST_EVT: begin
        if (evtValid & evtReady) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      beat_q <= 2'h0;
      ctx_q <= 64'h0000000000000000;
      cmdPtr_q <= 64'h0000000000000000;
      good_q <= 1'b0;
      tsTime_q <= 64'h0000000000000000;
      tsBi_q <= 14'h0000;
      tsDt_q <= 13'h0000;
      cmdReady <= 1'b0;
      memValid <= 1'b0;
      memAddr <= 64'h0000000000000000;
      memData <= `FTC_ZERO32;
      evtValid <= 1'b0;
      evtCmdPtr <= 64'h0000000000000000;
      evtSlot <= 8'h00;
      evtParam <= 24'h000000;
      evtCode <= 8'h00;
    end else begin
      state_q <= state_d;
      cmdReady <= enable_q & (state_d == ST_IDLE) & ~take;
      if (take) begin
        ctx_q <= cmdCtxPtr;
        cmdPtr_q <= cmdAddr;
        good_q <= cmdOk;
        // one-cycle snapshot of all three time values
        tsTime_q <= sysTime;
        tsBi_q <= busInterval;
        tsDt_q <= deltaTime;
        beat_q <= 2'h0;
      end
      if (state_q == ST_PRE) begin
        memValid <= 1'b1;
        memAddr <= ctx_q + ctxOff(beat_q);
        memData <= ctxWord(beat_q, tsTime_q, tsBi_q, tsDt_q);
      end
      if ((state_q == ST_WR) & memValid & memReady) begin
        if (beat_q == `FTC_BEATS) begin
          memValid <= 1'b0;
        end else begin
          beat_q <= beat_q + 2'h1;
          memAddr <= ctx_q + ctxOff(beat_q + 2'h1);
          memData <= ctxWord(beat_q + 2'h1, tsTime_q, tsBi_q, tsDt_q);
        end
      end
      if ((state_d == ST_EVT) & (state_q != ST_EVT)) begin
        evtValid <= 1'b1;
        evtCmdPtr <= (state_q == ST_IDLE) ? cmdAddr : cmdPtr_q;
        evtSlot <= `FTC_SLOT_ZERO;
        evtParam <= ((state_q == ST_IDLE) ? cmdOk : good_q) ? `FTC_PARAM_TS
          : `FTC_PARAM_NONE;
        evtCode <= ((state_q == ST_IDLE) ? cmdOk : good_q) ? CODE_OK : CODE_BAD;
      end else if (evtValid & evtReady) begin
        evtValid <= 1'b0;
      end
    end
  end

  ftc_set_filter #(
    .NSETS(NSETS),
    .FW(FW),
    .SW(SW)
  ) u_filter (
    .accFn(accFn),
    .accIsDb(accIsDb),
    .accSet(accSet),
    .dbOwner(dbMap_q),
    .irOwner(irMap_q),
    .grant(grantW)
  );

  // per-function runtime and doorbell sets are decoded here, not emulated
  always @(posedge clk_sys) begin
    if (rst) begin
      accGrant <= 1'b0;
      accDone <= 1'b0;
      virtCapVisible <= 1'b0;
    end else begin
      accDone <= accValid;
      accGrant <= accValid & grantW;
      virtCapVisible <= accFn == {FW{1'b0}};
    end
  end

  assign evDone = evtValid & evtReady & (evtCode == CODE_OK);
  assign evErr = evtValid & evtReady & (evtCode != CODE_OK);
  assign evDeny = accValid & ~grantW;
  assign evVec = {evDeny, evErr, evDone};
  assign w1c = (wrEn & (paddr == `FTC_REG_STAT)) ? pwdata[`FTC_ST_W-1:0]
    : {`FTC_ST_W{1'b0}};
  // a new event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~w1c) | evVec;

  always @(posedge clk_sys) begin
    if (rst) begin
      enable_q <= 1'b0;
      stat_q <= {`FTC_ST_W{1'b0}};
      mask_q <= {`FTC_ST_W{1'b0}};
      rtsOff_q <= `FTC_RTSOFF_RST;
      dbOff_q <= `FTC_DBOFF_RST;
      dbMap_q <= {NSETS*FW{1'b0}};
      irMap_q <= {NSETS*FW{1'b0}};
      count_q <= `FTC_ZERO32;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `FTC_ZERO32;
    end else begin
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
      pready <= 1'b1;
      if (evDone) begin
        count_q <= count_q + 32'h00000001;
      end
      if (setupPh) begin
        pslverr <= ~mapped(paddr);
        case (paddr)
          `FTC_REG_CTRL: prdata <= {31'h00000000, enable_q};
          `FTC_REG_STAT: prdata <= {29'h00000000, stat_q};
          `FTC_REG_MASK: prdata <= {29'h00000000, mask_q};
          `FTC_REG_RTSOFF: prdata <= rtsOff_q;
          `FTC_REG_DBOFF: prdata <= dbOff_q;
          `FTC_REG_DBMAP: prdata <= {{(32-NSETS*FW){1'b0}}, dbMap_q};
          `FTC_REG_IRMAP: prdata <= {{(32-NSETS*FW){1'b0}}, irMap_q};
          `FTC_REG_COUNT: prdata <= count_q;
          default: prdata <= `FTC_ZERO32;
        endcase
      end
      if (wrEn) begin
        case (paddr)
          `FTC_REG_CTRL: enable_q <= pwdata[0];
          `FTC_REG_MASK: mask_q <= pwdata[`FTC_ST_W-1:0];
          // independent page-aligned bases for runtime and doorbell groups
          `FTC_REG_RTSOFF: rtsOff_q <= pwdata & `FTC_OFF_ALIGN;
          `FTC_REG_DBOFF: dbOff_q <= pwdata & `FTC_OFF_ALIGN;
          `FTC_REG_DBMAP: dbMap_q <= pwdata[NSETS*FW-1:0];
          `FTC_REG_IRMAP: irMap_q <= pwdata[NSETS*FW-1:0];
          default: ;
        endcase
      end
    end
  end
endmodule // ftc_time_corr

// File: ftc_host_model.sv
`timescale 1ns/1ps
module ftc_host_model (
  // clock and reset
  input clk_sys, rst,
  // pacing and buffer base
  input slow,
  input [63:0] ctxBase,
  // memory write and event
  input memValid, evtValid,
  input [63:0] memAddr,
  input [31:0] memData,
  output reg memReady, evtReady,
  // buffer view
  output reg [127:0] ctx,
  output reg [7:0] nWr
);
  reg tick_q;
  always @(posedge clk_sys) begin
    tick_q <= rst ? 1'b0 : ~tick_q;
    memReady <= !rst && (!slow || tick_q);
    evtReady <= !rst && (!slow || tick_q);
    nWr <= rst ? 8'h00 : nWr + (memValid && memReady);
    // only the reserved buffer takes writes
    if (memValid && memReady && memAddr[63:4] == ctxBase[63:4]) begin
      ctx[memAddr[3:2]*32 +: 32] <= memData;
    end
    // poison once the event is taken, so stale words never pass
    if (rst || (evtValid && evtReady)) begin
      ctx <= {128{1'b1}};
    end
  end
endmodule // ftc_host_model

// File: ftc_time_corr_props.sv
`timescale 1ns/1ps
module ftc_time_corr_props #(parameter [7:0] CODE_OK = 8'h01, parameter FW = 3, parameter SW = 3) (
  // clock and reset
  input clk_sys, rst,
  // watched ports
  input memValid, memReady, evtValid, cmdValid, cmdReady, accValid, accIsDb, accGrant,
  input accDone, virtCapVisible,
  input [63:0] memAddr,
  input [31:0] memData,
  input [7:0] evtSlot, evtCode,
  input [23:0] evtParam,
  input [FW-1:0] accFn,
  input [SW-1:0] accSet
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  evt_slot_a: assert property (evtValid |-> evtSlot == 8'h00) else $error("slot not zero");
  evt_param_a: assert property (evtValid |-> (evtParam == 24'h001000 && evtCode == CODE_OK)
    || (evtParam == 24'h000000 && evtCode != CODE_OK)) else $error("bad parameter");
  mem_hold_a: assert property (memValid && !memReady |=> memValid && $stable(memAddr)
    && $stable(memData)) else $error("write beat changed");
  rsvd_word_a: assert property (memValid && memAddr[3:0] == 4'h8 |-> memData == 32'h00000000)
    else $error("reserved word not zero");
  evt_after_a: assert property (memValid && memReady && memAddr[3:0] == 4'hC |=> evtValid
    && !memValid) else $error("event late");
  cmd_busy_a: assert property (cmdValid && cmdReady |=> !cmdReady)
    else $error("second command taken");
  busy_ready_a: assert property (memValid || evtValid |-> !cmdReady)
    else $error("ready while busy");
  virt_cap_a: assert property (accValid |=> accDone && virtCapVisible == ($past(accFn) == 0))
    else $error("capability flag wrong");
  grant_zero_a: assert property (accValid && !accIsDb && accSet == 0 |=>
    accGrant == ($past(accFn) == 0)) else $error("set zero grant wrong");
  cover property (evtValid && evtCode == CODE_OK);
  cover property (evtValid && evtCode != CODE_OK);
  cover property (memValid && !memReady);
  cover property (accDone && !accGrant);
endmodule // ftc_time_corr_props
bind ftc_time_corr ftc_time_corr_props #(.CODE_OK(CODE_OK), .FW(FW), .SW(SW)) props_inst (
  .clk_sys(clk_sys), .rst(rst), .memValid(memValid), .memReady(memReady),
  .evtValid(evtValid), .cmdValid(cmdValid), .cmdReady(cmdReady), .accValid(accValid),
  .accIsDb(accIsDb), .accGrant(accGrant), .accDone(accDone), .virtCapVisible(virtCapVisible),
  .memAddr(memAddr), .memData(memData), .evtSlot(evtSlot), .evtCode(evtCode),
  .evtParam(evtParam), .accFn(accFn), .accSet(accSet));

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cmdValid = 0, cmdIsSet = 0;
  logic accValid = 0, accIsDb = 0, slow = 0, pready, pslverr, cmdReady, memValid, memReady;
  logic evtValid, evtReady, accGrant, accDone, virtCapVisible, irq, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, memData;
  logic [63:0] cmdAddr = 64'h4000000000000000, cmdCtxPtr = 64'h8000000012340000;
  logic [63:0] sysTime = 64'h0123456789ABCDEF, memAddr, evtCmdPtr;
  logic [15:0] cmdCapSel = 0;
  logic [2:0] cmdSubtype = 0, accFn = 0, accSet = 0;
  logic [7:0] cmdSlot = 0, evtSlot, evtCode, nWr;
  logic [4:0] cmdEp = 0;
  logic [13:0] busInterval = 14'h3FF0;
  logic [12:0] deltaTime = 13'h1FF0;
  logic [23:0] evtParam;
  logic [127:0] ctx;
  int err_total = 0, n_checks = 0, goods = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    sysTime <= sysTime + 64'h0000000100000001;
    busInterval <= busInterval + 14'h0001;
    deltaTime <= deltaTime + 13'h0003;
  end
  ftc_time_corr ftc_time_corr_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdAddr(cmdAddr), .cmdCtxPtr(cmdCtxPtr), .cmdCapSel(cmdCapSel), .cmdSubtype(cmdSubtype),
    .cmdSlot(cmdSlot), .cmdEp(cmdEp), .cmdIsSet(cmdIsSet), .sysTime(sysTime),
    .busInterval(busInterval), .deltaTime(deltaTime), .memValid(memValid),
    .memReady(memReady), .memAddr(memAddr), .memData(memData), .evtValid(evtValid),
    .evtReady(evtReady), .evtCmdPtr(evtCmdPtr), .evtSlot(evtSlot), .evtParam(evtParam),
    .evtCode(evtCode), .accValid(accValid), .accFn(accFn), .accIsDb(accIsDb),
    .accSet(accSet), .accGrant(accGrant), .accDone(accDone),
    .virtCapVisible(virtCapVisible), .irq(irq));
  ftc_host_model ftc_host_model_inst (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .ctxBase(cmdCtxPtr), .memValid(memValid), .evtValid(evtValid), .memAddr(memAddr),
    .memData(memData), .memReady(memReady), .evtReady(evtReady), .ctx(ctx), .nWr(nWr));
  task end_of_test;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bound(input int i);
    if (i >= 200) begin
      err_total++;
      end_of_test;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    for (i = 0; i < 200 && pready !== 1'b1; i++) @(posedge clk_sys);
    bound(i);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask
  task acc(input logic [2:0] f, input logic db, input logic [2:0] s, input logic g);
    @(posedge clk_sys);
    accValid <= 1;
    accFn <= f;
    accIsDb <= db;
    accSet <= s;
    @(posedge clk_sys);
    accValid <= 0;
    @(posedge clk_sys);
    chk("grant", g, accGrant);
    chk("virtcap", f == 3'h0, virtCapVisible);
  endtask
  task cmd(input logic [15:0] c, input logic [2:0] st, input logic [7:0] sl,
    input logic [4:0] ep, input logic set, input logic sw);
    logic [63:0] t;
    logic [13:0] b;
    logic [12:0] d;
    logic [7:0] w;
    logic ok;
    int i;
    ok = c[12] && !set && st == 3'h1 && sl == 8'h00 && ep == 5'h00;
    @(posedge clk_sys);
    slow <= sw;
    cmdValid <= 1;
    cmdAddr <= cmdAddr + 64'h40;
    cmdCtxPtr <= cmdCtxPtr + 64'h100;
    {cmdCapSel, cmdSubtype, cmdSlot, cmdEp, cmdIsSet} <= {c, st, sl, ep, set};
    @(posedge clk_sys);
    for (i = 0; i < 200 && cmdReady !== 1'b1; i++) @(posedge clk_sys);
    bound(i);
    {t, b, d, w} = {sysTime, busInterval, deltaTime, nWr};
    cmdValid <= 0;
    @(posedge clk_sys);
    for (i = 0; i < 200 && (evtValid & evtReady) !== 1'b1; i++) @(posedge clk_sys);
    bound(i);
    chk("evtptr", cmdAddr, evtCmdPtr);
    chk("evtslot", 0, evtSlot);
    chk("evtparam", ok ? 24'h001000 : 24'h000000, evtParam);
    chk("evtcode", ok ? 8'h01 : 8'h05, evtCode);
    chk("writes", ok ? w + 8'h04 : w, nWr);
    if (ok) begin
      chk("timehi", t[63:32], ctx[31:0]);
      chk("timelo", t[31:0], ctx[63:32]);
      chk("rsvd", 0, ctx[95:64]);
      chk("interval", {2'b00, b, 3'b000, d}, ctx[127:96]);
    end
    goods += ok;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    rchk("rtsoff", 12'h00C, 32'h00002000);
    rchk("dboff", 12'h010, 32'h00003000);
    apb(1, 12'h00C, 32'h00005ABC);
    rchk("rtsoffw", 12'h00C, 32'h00005000);
    apb(0, 12'h100, 0);
    chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    apb(1, 12'h000, 32'h00000001);
    cmd(16'h1000, 3'h1, 8'h00, 5'h00, 0, 0);
    cmd(16'hF000, 3'h1, 8'h00, 5'h00, 0, 1);
    cmd(16'h1000, 3'h1, 8'h00, 5'h00, 1, 0);
    cmd(16'h0800, 3'h1, 8'h00, 5'h00, 0, 0);
    cmd(16'h1000, 3'h0, 8'h00, 5'h00, 0, 1);
    cmd(16'h1000, 3'h2, 8'h00, 5'h00, 0, 0);
    cmd(16'h1000, 3'h1, 8'h01, 5'h00, 0, 0);
    cmd(16'h1000, 3'h1, 8'h00, 5'h01, 0, 0);
    rchk("count", 12'h01C, goods);
    rchk("stat", 12'h004, 32'h00000003);
    chk("irqmasked", 0, irq);
    apb(1, 12'h008, 32'h00000001);
    rchk("mask", 12'h008, 32'h00000001);
    chk("irqon", 1, irq);
    apb(1, 12'h004, 32'h00000001);
    rchk("w1c", 12'h004, 32'h00000002);
    chk("irqclr", 0, irq);
    apb(1, 12'h014, 32'h000000C0);
    acc(3'h3, 1, 3'h2, 1);
    acc(3'h1, 1, 3'h2, 0);
    acc(3'h0, 0, 3'h0, 1);
    acc(3'h2, 0, 3'h0, 0);
    rchk("deny", 12'h004, 32'h00000006);
    end_of_test;
  end
endmodule // tb
